// *** spare_pin_pkg.sv ***
// package for the spare pin output control block
// assumes an apb slave with 32-bit data and byte addresses
package spare_pin_pkg;
  localparam int unsigned PIN_COUNT = 8;
  // register indices; one aligned 32-bit word each, byte address is index times four
  localparam logic [11:0] PIN_OUTPUT_ENABLE_INDEX = 12'h044;
  localparam logic [11:0] PIN_OUTPUT_LEVEL_INDEX = 12'h045;
  localparam logic [11:0] PIN_INPUT_STATE_INDEX = 12'h046;
  localparam logic [11:0] PIN_OUTPUT_ENABLE_ADDR = {PIN_OUTPUT_ENABLE_INDEX[9:0], 2'b00};
  localparam logic [11:0] PIN_OUTPUT_LEVEL_ADDR = {PIN_OUTPUT_LEVEL_INDEX[9:0], 2'b00};
  localparam logic [11:0] PIN_INPUT_STATE_ADDR = {PIN_INPUT_STATE_INDEX[9:0], 2'b00};
  localparam logic [7:0] PIN_OUTPUT_ENABLE_RESET = 8'h00;
  localparam logic [7:0] PIN_OUTPUT_LEVEL_RESET = 8'h00;
  localparam int unsigned SIG_INPUT_BIT = 7;
  localparam int unsigned CLK_OUTPUT_BIT = 6;
  localparam int unsigned HOST_SELECT_1_BIT = 5;
  localparam int unsigned HOST_SELECT_0_BIT = 4;
  // the four test port pins sit in bits 3..0
  localparam logic [7:0] TEST_PORT_MASK = 8'h0f;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_type;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_SETUP = 2'b01,
    APB_ACCESS = 2'b10
  } apb_phase_type;
endpackage

// *** spare_pin_output_control.sv ***
// spare pin output control: per-pin enable and level registers over apb
// assumes pin inputs synchronous to clk_i; function inputs come from the
// dedicated logic; the pad wire is resolved outside from out/oe
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
module spare_pin_output_control (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic boundary_scan_en_i,
  input wire logic [7:0] func_out_i,
  input wire logic [7:0] func_oe_i,
  input wire logic [7:0] pin_in_i,
  output logic [7:0] pin_out_o,
  output logic [7:0] pin_oe_o
);
  logic [7:0] pin_output_enable_reg;
  logic [7:0] pin_output_level_reg;
  logic [7:0] pin_input_state_reg;
  logic [7:0] eff_enable;
  spare_pin_pkg::pin_drive_type drive_next;
  logic wr_en;
  logic rd_setup;
  logic addr_hit;

  function automatic logic known_addr(input logic [11:0] a);
    known_addr = (a == spare_pin_pkg::PIN_OUTPUT_ENABLE_ADDR) ||
                 (a == spare_pin_pkg::PIN_OUTPUT_LEVEL_ADDR) ||
                 (a == spare_pin_pkg::PIN_INPUT_STATE_ADDR);
  endfunction

  // zero-wait slave: answer comes in the first access cycle
  assign addr_hit = known_addr(paddr_i);
  assign wr_en = psel_i && penable_i && pwrite_i && pready_o;
  assign rd_setup = psel_i && !penable_i && !pwrite_i;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= psel_i && !penable_i && !addr_hit;
    end
  end

  // read data captured at setup so it stands through the access cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prdata_o <= spare_pin_pkg::READ_ZERO;
    end else if (rd_setup) begin
      case (paddr_i)
        spare_pin_pkg::PIN_OUTPUT_ENABLE_ADDR: begin
          prdata_o <= {24'h000000, pin_output_enable_reg};
        end
        spare_pin_pkg::PIN_OUTPUT_LEVEL_ADDR: begin
          prdata_o <= {24'h000000, pin_output_level_reg};
        end
        spare_pin_pkg::PIN_INPUT_STATE_ADDR: begin
          prdata_o <= {24'h000000, pin_input_state_reg};
        end
        default: begin
          prdata_o <= spare_pin_pkg::READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_output_enable_reg <= spare_pin_pkg::PIN_OUTPUT_ENABLE_RESET;
    end else if (wr_en && paddr_i == spare_pin_pkg::PIN_OUTPUT_ENABLE_ADDR) begin
      pin_output_enable_reg <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_output_level_reg <= spare_pin_pkg::PIN_OUTPUT_LEVEL_RESET;
    end else if (wr_en && paddr_i == spare_pin_pkg::PIN_OUTPUT_LEVEL_ADDR) begin
      pin_output_level_reg <= pwdata_i[7:0];
    end
  end

  // one-cycle sample keeps the readback registered
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_input_state_reg <= 8'h00;
    end else begin
      pin_input_state_reg <= pin_in_i;
    end
  end

  // test-port enables masked off while boundary scan owns those pins
  always_comb begin
    eff_enable = pin_output_enable_reg;
    if (boundary_scan_en_i) begin
      eff_enable = pin_output_enable_reg & ~spare_pin_pkg::TEST_PORT_MASK;
    end
  end

  always_comb begin
    for (int i = 0; i < spare_pin_pkg::PIN_COUNT; i++) begin
      if (eff_enable[i]) begin
        drive_next.out[i] = pin_output_level_reg[i];
        drive_next.oe[i] = 1'b1;
      end else begin
        drive_next.out[i] = func_out_i[i];
        drive_next.oe[i] = func_oe_i[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_out_o <= 8'h00;
      pin_oe_o <= 8'h00;
    end else begin
      pin_out_o <= drive_next.out;
      pin_oe_o <= drive_next.oe;
    end
  end
endmodule

// *** spare_pin_monitor.sv ***
// pad and apb handshake checker, bound to the spare pin block
`timescale 1ns/100ps
module spare_pin_monitor (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic boundary_scan_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [31:0] prdata_o,
  input wire logic [7:0] func_out_i,
  input wire logic [7:0] func_oe_i,
  input wire logic [7:0] pin_out_o,
  input wire logic [7:0] pin_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  AST_FN:
    assert property (!$past(srst_i) |-> (pin_oe_o | $past(func_oe_i)) == pin_oe_o)
      else $error("fn");
  AST_BS:
    assert property ($past(boundary_scan_en_i) && !$past(srst_i) |->
      ((pin_oe_o ^ $past(func_oe_i) | pin_out_o ^ $past(func_out_i)) & 8'h0f) == 8'h00)
      else $error("bs");
  AST_READY_AFTER_SETUP:
    assert property (psel_i && !penable_i |=> pready_o)
      else $error("no ready after setup");
  AST_READY_ONE_CYCLE:
    assert property (pready_o |=> !pready_o)
      else $error("ready held too long");
  AST_ERR_WITH_READY:
    assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
  AST_READ_UPPER_ZERO:
    assert property (pready_o |-> prdata_o[31:8] == 24'h000000)
      else $error("upper read bits set");
endmodule
bind spare_pin_output_control spare_pin_monitor mon_u (.*);

// *** spare_pin_board.sv ***
// board on the pads; undriven pads show the board's own level
`timescale 1ns/100ps
module spare_pin_board (
  input wire logic [7:0] pin_out_i, pin_oe_i, ext_i,
  output logic [7:0] pin_in_o
);
  assign pin_in_o = pin_oe_i & pin_out_i | ~pin_oe_i & ext_i;
endmodule

// *** spare_pin_output_control_tb.sv ***
// spare pin bench, board model on pads
`timescale 1ns/100ps
module spare_pin_output_control_tb;
  logic clk_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic boundary_scan_en_i = 0, pready_o, pslverr_o;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o;
  logic [7:0] func_out_i = '0, func_oe_i = '0, pin_in_i, pin_out_o, pin_oe_o, ext, en, lv;
  int seed = 81124, fail_count = 0, tests_run = 0;
  always #25 clk_i = ~clk_i;
  spare_pin_output_control dut_u (.*);
  spare_pin_board brd_u (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .ext_i(ext),
    .pin_in_o(pin_in_i));
  function automatic logic [7:0] pad();
    logic [7:0] v = boundary_scan_en_i ? en & 8'hf0 : en;
    return (v | func_oe_i) & (v & lv | ~v & func_out_i) | ~(v | func_oe_i) & ext;
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [32:0] x);
    @(posedge clk_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <=
      {1'b1, w, a, 24'hffffff, a == spare_pin_pkg::PIN_OUTPUT_LEVEL_ADDR ? lv : en};
    @(posedge clk_i) penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    tests_run += !w;
    if (!w && {pslverr_o, prdata_o} !== x) begin
      fail_count++;
      $display("MISMATCH %0t read %h", $time, a);
    end
    {psel_i, penable_i} <= 2'b00;
  endtask
  task automatic print_verdict;
    $display("%0d checks %0d bad", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #300us fail_count++;
    print_verdict;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 0;
    for (int i = 0; i < 40; i++) begin
      {func_out_i, func_oe_i, ext} <= $random(seed);
      boundary_scan_en_i <= i < 4 ? i[0] : $random(seed);
      {en, lv} = i < 4 ? 16'hff00 : $random(seed);
      apb(1, spare_pin_pkg::PIN_OUTPUT_ENABLE_ADDR, 0);
      apb(1, spare_pin_pkg::PIN_OUTPUT_LEVEL_ADDR, 0);
      apb(0, spare_pin_pkg::PIN_OUTPUT_ENABLE_ADDR, en);
      apb(0, spare_pin_pkg::PIN_OUTPUT_LEVEL_ADDR, lv);
      apb(0, spare_pin_pkg::PIN_INPUT_STATE_ADDR, pad());
      apb(0, 12'h11c, {1'b1, 32'h0});
    end
    print_verdict;
  end
endmodule
